//--- rtl/rbac_pkg.sv
package rbac_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] REG_BIT_CTRL = 8'h0C;
  localparam logic [7:0] REG_COLL_POS = 8'h0D;
  localparam logic [7:0] REG_ERROR = 8'h20;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h21;
  localparam logic [7:0] REG_IRQ_MASK = 8'h22;
  localparam logic [7:0] REG_STORE_INDEX = 8'h23;
  localparam logic [7:0] REG_STORE_DATA = 8'h24;

  // Field positions of the receive bit control register.
  localparam int CTRL_KEEP_BIT = 7;
  localparam int CTRL_ALIGN_LSB = 4;
  localparam int CTRL_COLL_INTEG_BIT = 3;
  localparam int CTRL_LAST_LSB = 0;

  // Field positions of the collision position register.
  localparam int COLL_VALID_BIT = 7;
  localparam int COLL_POS_LSB = 0;

  // Field positions of the error register.
  localparam int ERR_COLL_DET_BIT = 2;
  localparam int ERR_INTEG_BIT = 0;

  // Interrupt status and mask bit positions.
  localparam int IRQ_END_BIT = 0;
  localparam int IRQ_COLL_BIT = 1;
  localparam int IRQ_INTEG_BIT = 2;
  localparam int IRQ_BITS = 3;

  // Reset values.
  localparam logic KEEP_RESET = 1'b0;
  localparam logic [2:0] ALIGN_RESET = 3'h0;
  localparam logic COLL_INTEG_RESET = 1'b0;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 3'h0;

  // Bit position limits: 64 stored bit positions fit in the eight-byte store.
  localparam logic [6:0] POS_LIMIT = 7'h40;
  localparam logic [6:0] POS_MAX = 7'h7F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int STORE_DEPTH = 8;
  localparam int STORE_AW = 3;

  // Strobes and data from the receive decoder, one bit per bit strobe.
  typedef struct packed {
    logic start;
    logic bit_valid;
    logic bit_data;
    logic coll;
    logic eof_coll;
    logic integ;
    logic frame_end;
  } rbac_dec_s;

  // Plain register port from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rbac_bus_s;

endpackage : rbac_pkg

//--- rtl/rbac_byte_store.sv
`timescale 1ns/1ps
module rbac_byte_store (
  input wire logic clk_sys_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [rbac_pkg::STORE_AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [rbac_pkg::STORE_AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);
  import rbac_pkg::*;

  typedef struct packed {
    logic [STORE_DEPTH-1:0][7:0] mem;
    logic [7:0] q;
  } rbac_store_s;

  rbac_store_s s;
  rbac_store_s next_s;

  // Write first, then read the registered word; a read of the word written
  // in the same cycle returns the old contents.
  always_comb begin
    next_s = s;
    if (we_in) begin
      next_s.mem[waddr_in] = wdata_in;
    end
    next_s.q = s.mem[raddr_in];
  end

  // The array has no reset, so its contents are valid only once written.
  always_ff @(posedge clk_sys_in) begin
    if (ce_in) begin
      s <= next_s;
    end
  end

  assign rdata_out = s.q;

endmodule : rbac_byte_store

//--- rtl/rbac_rx_bit_align.sv
// Functional notes
// RL1: Clear keep bit zeroes bits after collision.
// RL2: Alignment field sets first stored bit position.
// RL3: Position past bit seven wraps to next byte.
// RL4: Zero alignment is byte mode, else bit mode; a partial final byte also ends in bit mode.
// RL5: Optional: collision also raises integrity error.
// RL6: Last-bits field counts valid bits, zero full.
// RL7: Last-bits written at end, cleared at start.
// RL8: Valid flag only for meaningful collision position.
// RL9: Position is zero-based index of collided bit.
// RL10: Only first 64 stored bits are reportable.
// RL11: Software uses position only when flagged valid.
// RL12: Alignment offset included in reported position.
// RL13: Collision sets flag and logs first position.
// RL14: Collision inside end-of-frame symbol not flagged.
// RL15: New reception clears stale collision information.
// RL16: Later collisions keep the first logged position.
`timescale 1ns/1ps
module rbac_rx_bit_align (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire rbac_pkg::rbac_dec_s dec_in,
  input wire rbac_pkg::rbac_bus_s bus_in,
  output logic [7:0] rd_data_out,
  output logic irq_out,
  output logic rx_active_out,
  output logic bit_oriented_out
);
  import rbac_pkg::*;

  typedef struct packed {
    logic keep;
    logic [2:0] align;
    logic coll_integ;
    logic [2:0] last_bits;
    logic rx_active;
    logic bit_oriented;
    logic [6:0] pos;
    logic coll_seen;
    logic coll_valid;
    logic [6:0] coll_pos;
    logic coll_det;
    logic integ_err;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [STORE_AW-1:0] store_index;
    logic [7:0] cur_byte;
    logic [7:0] rd_data;
    logic irq;
    logic mem_we;
    logic [STORE_AW-1:0] mem_waddr;
    logic [7:0] mem_wdata;
  } rbac_state_s;

  rbac_state_s s;
  rbac_state_s next_s;
  logic [7:0] store_q;
  logic bit_take;
  logic coll_hit;
  logic in_range;

  // Address match used by both the write and the read decode.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  // A bit counts only while a reception is open; a start in the same cycle wins.
  assign bit_take = dec_in.bit_valid && s.rx_active && !dec_in.start;
  assign coll_hit = bit_take && dec_in.coll && !dec_in.eof_coll; // RL14
  assign in_range = (s.pos < POS_LIMIT); // RL10

  // Received bytes are held in a small store that software reads by index.
  rbac_byte_store u_store (
    .clk_sys_in(clk_sys_in),
    .ce_in(ce_in),
    .we_in(s.mem_we),
    .waddr_in(s.mem_waddr),
    .wdata_in(s.mem_wdata),
    .raddr_in(s.store_index),
    .rdata_out(store_q)
  );

  // Next state: reception control, bit placement, collision log, bus and interrupts.
  always_comb begin
    logic bit_val;
    logic [7:0] byte_v;
    logic [IRQ_BITS-1:0] irq_set;
    logic [IRQ_BITS-1:0] irq_clr;
    bit_val = 1'b0;
    byte_v = 8'h00;
    irq_set = '0;
    irq_clr = '0;
    next_s = s;
    next_s.mem_we = 1'b0;
    next_s.rd_data = 8'h00;

    // A new reception resets placement and all per-frame results.
    if (dec_in.start) begin
      next_s.rx_active = 1'b1;
      next_s.pos = {4'h0, s.align}; // RL2 RL12
      next_s.cur_byte = 8'h00;
      next_s.last_bits = 3'h0; // RL7
      next_s.bit_oriented = (s.align != 3'h0); // RL4
      next_s.coll_seen = 1'b0;
      next_s.coll_valid = 1'b0; // RL15
      next_s.coll_pos = 7'h00; // RL15
      next_s.coll_det = 1'b0;
      next_s.integ_err = 1'b0;
    end

    // Place one received bit; the partial byte is rewritten on every in-range bit so
    // the store holds what has arrived so far within the first 64 positions.
    if (bit_take) begin
      bit_val = dec_in.bit_data && !(s.coll_seen && !s.keep); // RL1
      byte_v = s.cur_byte | ({7'h00, bit_val} << s.pos[2:0]); // RL2
      if (in_range) begin
        next_s.mem_we = 1'b1;
        next_s.mem_waddr = s.pos[5:3];
        next_s.mem_wdata = byte_v;
      end
      if (s.pos[2:0] == BIT_LAST) begin
        next_s.cur_byte = 8'h00; // RL3
      end else begin
        next_s.cur_byte = byte_v;
      end
      if (s.pos != POS_MAX) begin
        next_s.pos = s.pos + 7'h01; // RL3
      end
      if (dec_in.integ) begin
        next_s.integ_err = 1'b1;
        irq_set[IRQ_INTEG_BIT] = 1'b1;
      end
    end

    // Collision: flag always, log only the first one of the frame.
    if (coll_hit) begin
      next_s.coll_det = 1'b1; // RL13
      irq_set[IRQ_COLL_BIT] = 1'b1;
      if (s.coll_integ) begin
        next_s.integ_err = 1'b1; // RL5
        irq_set[IRQ_INTEG_BIT] = 1'b1;
      end
      if (!s.coll_seen) begin
        next_s.coll_seen = 1'b1; // RL16
        next_s.coll_valid = in_range; // RL8 RL10
        next_s.coll_pos = in_range ? s.pos : 7'h00; // RL9 RL12 RL13
      end
    end

    // End of frame: a partial final byte or an aligned start makes the frame
    // bit oriented, and only then is the valid-bit count reported.
    if (dec_in.frame_end && s.rx_active && !dec_in.start) begin
      next_s.rx_active = 1'b0;
      irq_set[IRQ_END_BIT] = 1'b1;
      if (s.bit_oriented || (s.pos[2:0] != 3'h0)) begin // RL4
        next_s.bit_oriented = 1'b1;
        next_s.last_bits = s.pos[2:0]; // RL6 RL7
      end
    end

    // Register writes; the last-bits field belongs to the receive path alone.
    if (bus_in.wr) begin
      if (reg_hit(bus_in.addr, REG_BIT_CTRL)) begin
        next_s.keep = bus_in.wdata[CTRL_KEEP_BIT];
        next_s.align = bus_in.wdata[CTRL_ALIGN_LSB +: 3];
        next_s.coll_integ = bus_in.wdata[CTRL_COLL_INTEG_BIT];
      end
      if (reg_hit(bus_in.addr, REG_IRQ_MASK)) begin
        next_s.irq_mask = bus_in.wdata[IRQ_BITS-1:0];
      end
      if (reg_hit(bus_in.addr, REG_STORE_INDEX)) begin
        next_s.store_index = bus_in.wdata[STORE_AW-1:0];
      end
    end

    // Register reads; unmapped addresses read as zero.
    if (bus_in.rd) begin
      if (reg_hit(bus_in.addr, REG_BIT_CTRL)) begin
        next_s.rd_data[CTRL_KEEP_BIT] = s.keep;
        next_s.rd_data[CTRL_ALIGN_LSB +: 3] = s.align;
        next_s.rd_data[CTRL_COLL_INTEG_BIT] = s.coll_integ;
        next_s.rd_data[CTRL_LAST_LSB +: 3] = s.last_bits;
      end
      if (reg_hit(bus_in.addr, REG_COLL_POS)) begin
        next_s.rd_data[COLL_VALID_BIT] = s.coll_valid;
        next_s.rd_data[COLL_POS_LSB +: 7] = s.coll_pos;
      end
      if (reg_hit(bus_in.addr, REG_ERROR)) begin
        next_s.rd_data[ERR_COLL_DET_BIT] = s.coll_det;
        next_s.rd_data[ERR_INTEG_BIT] = s.integ_err;
      end
      if (reg_hit(bus_in.addr, REG_IRQ_STATUS)) begin
        next_s.rd_data[IRQ_BITS-1:0] = s.irq_status;
        irq_clr = s.irq_status;
      end
      if (reg_hit(bus_in.addr, REG_IRQ_MASK)) begin
        next_s.rd_data[IRQ_BITS-1:0] = s.irq_mask;
      end
      if (reg_hit(bus_in.addr, REG_STORE_INDEX)) begin
        next_s.rd_data[STORE_AW-1:0] = s.store_index;
      end
      if (reg_hit(bus_in.addr, REG_STORE_DATA)) begin
        next_s.rd_data = store_q;
      end
    end

    // Sticky events: a set in the clearing read's cycle survives the clear.
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  // One register stage holds the whole state; the clock enable freezes it.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s <= '0;
      s.keep <= KEEP_RESET;
      s.align <= ALIGN_RESET;
      s.coll_integ <= COLL_INTEG_RESET;
      s.irq_mask <= IRQ_MASK_RESET;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // Every output is a state flip-flop.
  assign rd_data_out = s.rd_data;
  assign irq_out = s.irq;
  assign rx_active_out = s.rx_active;
  assign bit_oriented_out = s.bit_oriented;

  // Bits after the first collision are stored as zero unless kept.
  chk_zero_after_coll: assert property ( // RL1
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && bit_take && s.coll_seen && !s.keep && in_range)
    |=> (s.mem_we && !s.mem_wdata[$past(s.pos[2:0])]))
    else $error("bit after collision was not forced to zero");

  // The first bit lands at the alignment position.
  chk_first_pos: assert property ( // RL2
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && dec_in.start) |=> (s.pos == {4'h0, $past(s.align)} && s.rx_active))
    else $error("start position does not follow alignment");

  // Leaving bit seven moves to bit zero of the next byte with a clean byte.
  chk_byte_wrap: assert property ( // RL3
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && bit_take && s.pos[2:0] == 3'h7 && s.pos != POS_MAX)
    |=> (s.pos[2:0] == 3'h0 && s.pos[6:3] == $past(s.pos[6:3]) + 4'h1 && s.cur_byte == 8'h00))
    else $error("placement did not wrap to next byte");

  // Start clears the valid-bit count and the collision log.
  chk_start_clear: assert property ( // RL7 RL15
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && dec_in.start)
    |=> (s.last_bits == 3'h0 && !s.coll_valid && s.coll_pos == 7'h00 && !s.coll_det))
    else $error("start left stale results");

  // Collision raises the integrity error only when so configured.
  chk_coll_integ: assert property ( // RL5
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && coll_hit && s.coll_integ) |=> (s.integ_err && s.coll_det))
    else $error("collision did not raise integrity error");

  // A valid position always lies inside the first 64 stored bits.
  chk_valid_range: assert property ( // RL8 RL10
    @(posedge clk_sys_in) disable iff (reset_in)
    s.coll_valid |-> (s.coll_pos < POS_LIMIT && s.coll_seen))
    else $error("valid flag set for unreportable position");

  // The first collision position is logged with the alignment included.
  chk_first_log: assert property ( // RL9 RL12 RL13
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && coll_hit && !s.coll_seen && in_range)
    |=> (s.coll_valid && s.coll_pos == $past(s.pos)))
    else $error("first collision position not logged");

  // Once logged, the position holds until the next start.
  chk_coll_hold: assert property ( // RL16
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && s.coll_seen && !dec_in.start) |=> ($stable(s.coll_pos) && $stable(s.coll_valid)))
    else $error("later collision changed the log");

  // A collision marked as part of the end-of-frame symbol is not flagged.
  chk_eof_coll: assert property ( // RL14
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !s.coll_det && !dec_in.start && dec_in.eof_coll) |=> !s.coll_det)
    else $error("end-of-frame collision was flagged");

  // The end of a partial final byte reports its valid-bit count.
  chk_last_bits: assert property ( // RL6
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && dec_in.frame_end && s.rx_active && !dec_in.start && s.pos[2:0] != 3'h0)
    |=> (s.last_bits == $past(s.pos[2:0]) && s.bit_oriented && !s.rx_active))
    else $error("last-bits count wrong at frame end");

  // The interrupt line follows the unmasked sticky bits.
  chk_irq_level: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    s.irq == |(s.irq_status & s.irq_mask))
    else $error("interrupt level disagrees with status");

  // The alignment at start decides the bit-oriented flag until the frame's end strobe.
  chk_start_mode: assert property ( // RL4
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && dec_in.start) |=> (s.bit_oriented == ($past(s.align) != 3'h0)))
    else $error("frame mode does not follow alignment");

  // In-range bits are written to the byte that holds their stored position.
  chk_store_addr: assert property ( // RL2 RL3
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && bit_take && in_range) |=> (s.mem_we && s.mem_waddr == $past(s.pos[5:3])))
    else $error("bit stored in the wrong byte");

  // Bits past the reportable range would alias into the store, so they are dropped.
  chk_store_limit: assert property ( // RL10
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && bit_take && !in_range) |=> !s.mem_we)
    else $error("bit past the store limit was written");

  // Only the receive path changes the valid-bit count, never a register write.
  chk_last_owned: assert property ( // RL7
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !dec_in.start && !dec_in.frame_end) |=> $stable(s.last_bits))
    else $error("valid-bit count changed outside frame edges");

  // A collision in the cycle of a clearing read still leaves its status bit.
  chk_coll_status: assert property ( // RL13
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && coll_hit) |=> s.irq_status[IRQ_COLL_BIT])
    else $error("collision status lost");

  // A status read with no event in its cycle clears every bit and the line.
  chk_status_clear: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && bus_in.rd && bus_in.addr == REG_IRQ_STATUS && !bit_take && !dec_in.frame_end)
    |=> (s.irq_status == '0 && !s.irq))
    else $error("status read did not clear");

  // Read data stand for one cycle only, so a stale value is never taken twice.
  chk_rd_one_cycle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !bus_in.rd) |=> (s.rd_data == 8'h00))
    else $error("read data outlived the read");

  // A low clock enable holds every state bit outside reset, whatever the other inputs do.
  chk_ce_freeze: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!ce_in && !reset_in) |=> $stable(s))
    else $error("state changed while clock enable was low");

endmodule : rbac_rx_bit_align

//--- tb/rbac_card_model.sv
`timescale 1ns/1ps
// Card side of the link as seen through the receive decoder: one strobe every other cycle.
module rbac_card_model (
  input wire logic clk_sys_in,
  output rbac_pkg::rbac_dec_s dec_out
);
  import rbac_pkg::*;

  // Idle at time zero so no stray strobe reaches the block during reset.
  initial begin
    dec_out = '0;
  end

  // One strobe cycle, then idle. The data line shows the inverse afterwards,
  // so a stale bit is never mistaken for a fresh one.
  task automatic pulse(input rbac_dec_s v);
    @(posedge clk_sys_in);
    dec_out <= v;
    @(posedge clk_sys_in);
    dec_out <= '{bit_data: ~v.bit_data, default: 1'b0};
  endtask : pulse

  // Whole frame: start, n data bits LSB first with collision and EOF marks, then end.
  task automatic frame(input int n, input logic [79:0] d, input logic [79:0] c,
                       input logic [79:0] e);
    rbac_dec_s v;
    pulse('{start: 1'b1, default: 1'b0});
    for (int i = 0; i < n; i++) begin
      v = '0;
      v.bit_valid = 1'b1;
      v.bit_data = d[i];
      v.coll = c[i];
      v.eof_coll = e[i];
      pulse(v);
    end
    pulse('{frame_end: 1'b1, default: 1'b0});
  endtask : frame
endmodule : rbac_card_model

//--- tb/rbac_rx_bit_align_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module rbac_rx_bit_align_tb;
  import rbac_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic ce_in = 1'b1;
  rbac_dec_s dec;
  rbac_bus_s bus = '0;
  logic [7:0] rd_data;
  logic irq;
  logic rx_active;
  logic bit_oriented;
  int num_errors = 0;
  int comparisons = 0;

  // Free running system clock, 100 ns period.
  always #50 clk_sys_in = ~clk_sys_in;

  rbac_card_model card_u (.clk_sys_in(clk_sys_in), .dec_out(dec));

  rbac_rx_bit_align dut_u (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in), .dec_in(dec),
    .bus_in(bus), .rd_data_out(rd_data), .irq_out(irq), .rx_active_out(rx_active),
    .bit_oriented_out(bit_oriented)
  );

  // Lets one edge pass and its updates land before anything is sampled.
  task automatic step;
    @(posedge clk_sys_in);
    #1;
  endtask : step

  // Single cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
  endtask : wr

  // Read strobe, then compare the data in the one cycle where it stands.
  // The mask hides store bits that a partial byte fills with zeros, not received bits.
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus.rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, rd_data & m)
  endtask : chk_rd

  // Store reads are registered: the index needs two cycles to show.
  task automatic chk_store(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
    wr(REG_STORE_INDEX, i);
    repeat (2) step;
    chk_rd(REG_STORE_DATA, e, m);
  endtask : chk_store

  task automatic final_report;
    $display("Errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    final_report();
  end

  // Main sequence: reset, register access, then four frames with collisions.
  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    chk_rd(REG_BIT_CTRL, 8'h00);
    chk_rd(REG_COLL_POS, 8'h00);
    chk_rd(REG_IRQ_MASK, 8'h00);
    chk_rd(8'h30, 8'h00);
    wr(REG_BIT_CTRL, 8'h4F);
    chk_rd(REG_BIT_CTRL, 8'h48);
    wr(REG_IRQ_MASK, 8'h01);
    // Align 4, collisions on bits 3 and 5, bits after the first forced low.
    card_u.frame(7, 80'h5D, 80'h28, 80'h0);
    step;
    `CHK("irq", 1'b1, irq)
    `CHK("bit oriented", 1'b1, bit_oriented)
    `CHK("rx active", 1'b0, rx_active)
    wr(REG_COLL_POS, 8'h00);
    chk_rd(REG_COLL_POS, 8'h87);
    chk_rd(REG_BIT_CTRL, 8'h4B);
    chk_rd(REG_ERROR, 8'h05);
    chk_rd(REG_IRQ_STATUS, 8'h07);
    chk_rd(REG_IRQ_STATUS, 8'h00);
    step;
    `CHK("irq", 1'b0, irq)
    chk_store(8'h00, 8'hD0, 8'hF0);
    chk_store(8'h01, 8'h00, 8'h07);
    // Byte mode, bits kept, EOF collision on bit 2 ignored, collision on bit 8.
    wr(REG_BIT_CTRL, 8'h80);
    wr(REG_IRQ_MASK, 8'h00);
    card_u.frame(16, 80'hFFA5, 80'h0104, 80'h0004);
    step;
    `CHK("bit oriented", 1'b0, bit_oriented)
    `CHK("irq masked", 1'b0, irq)
    chk_rd(REG_COLL_POS, 8'h88);
    chk_rd(REG_BIT_CTRL, 8'h80);
    chk_rd(REG_ERROR, 8'h04);
    chk_rd(REG_IRQ_STATUS, 8'h03);
    chk_store(8'h00, 8'hA5, 8'hFF);
    chk_store(8'h01, 8'hFF, 8'hFF);
    chk_rd(REG_STORE_INDEX, 8'h01);
    // Collision on bit 64 lies past the reportable range.
    card_u.frame(65, 80'h0, 80'h1_0000_0000_0000_0000, 80'h0);
    chk_rd(REG_COLL_POS, 8'h00);
    chk_rd(REG_ERROR, 8'h04);
    chk_rd(REG_BIT_CTRL, 8'h81);
    // Collision on bit 63 is the last reportable position.
    card_u.frame(64, 80'h0, 80'h8000_0000_0000_0000, 80'h0);
    chk_rd(REG_COLL_POS, 8'hBF);
    chk_rd(REG_BIT_CTRL, 8'h80);
    // Clock enable low: the write and the start strobe are both lost.
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    wr(REG_BIT_CTRL, 8'h38);
    card_u.pulse('{start: 1'b1, default: 1'b0});
    @(posedge clk_sys_in);
    ce_in <= 1'b1;
    chk_rd(REG_BIT_CTRL, 8'h80);
    `CHK("rx active frozen", 1'b0, rx_active)
    // A decoder integrity error on an open frame, seen through the mask.
    wr(REG_IRQ_MASK, 8'h04);
    chk_rd(REG_IRQ_MASK, 8'h04);
    chk_rd(REG_IRQ_STATUS, 8'h03);
    card_u.pulse('{start: 1'b1, default: 1'b0});
    card_u.pulse('{bit_valid: 1'b1, bit_data: 1'b1, integ: 1'b1, default: 1'b0});
    step;
    `CHK("irq integrity", 1'b1, irq)
    `CHK("rx active open", 1'b1, rx_active)
    chk_rd(REG_ERROR, 8'h01);
    chk_rd(REG_COLL_POS, 8'h00);
    // Reset in mid-frame closes the reception and restores the control, mask and status registers.
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    chk_rd(REG_BIT_CTRL, 8'h00);
    chk_rd(REG_IRQ_MASK, 8'h00);
    chk_rd(REG_IRQ_STATUS, 8'h00);
    `CHK("rx active reset", 1'b0, rx_active)
    `CHK("irq reset", 1'b0, irq)
    // An end strobe with no reception open is ignored.
    card_u.pulse('{frame_end: 1'b1, default: 1'b0});
    chk_rd(REG_IRQ_STATUS, 8'h00);
    final_report();
  end
endmodule : rbac_rx_bit_align_tb
